// ===== core/pfs_pkg.sv
// ----------------------------------------------------------------
// constants and carriers for the port function select block
// ----------------------------------------------------------------
package pfs_pkg;

  // register byte addresses and reset values
  localparam logic [31:0] P1_ADDR  = 32'hFFFF0D04;
  localparam logic [31:0] P2_ADDR  = 32'hFFFF0D08;
  localparam logic [31:0] P1_RESET = 32'h10000000;
  localparam logic [31:0] P2_RESET = 32'h01000000;

  // port-1 field positions
  localparam int P1_TXD_BIT = 4;
  localparam int P1_RXD_BIT = 0;

  // port-2 field positions
  localparam int P2_TEST_IF_BIT = 24;
  localparam int P2_LINTX_BIT   = 20;
  localparam int P2_LINRX_BIT   = 16;
  localparam int P2_RXOUT_BIT   = 4;
  localparam int P2_TXIN_BIT    = 0;

  // two-way pin indices
  localparam int PIN_RX    = 0;
  localparam int PIN_TX    = 1;
  localparam int PIN_TXIN  = 2;
  localparam int PIN_RXOUT = 3;
  localparam int NPIN      = 4;

  // bus answers and line levels
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       LINE_IDLE   = 1'h1;

  // drive of one pad
  typedef struct packed {
    logic out;
    logic oe;
  } pfs_pad_t;

  // write payload held by the bus slave
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } pfs_wr_t;

endpackage

// ===== core/pfs_pad_mux.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// one pad: gpio or alternate function
// ----------------------------------------------------------------
module pfs_pad_mux (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            sel,
  input  pfs_pkg::pfs_pad_t    alt_drv,
  input  pfs_pkg::pfs_pad_t    gpio_drv,
  input  wire logic            pin_in,
  output pfs_pkg::pfs_pad_t    pad_drv_q,
  output logic                 gpio_in_q,
  output logic                 alt_in
);

  // unselected function sees an idle line, not a stray gpio level
  assign alt_in = sel ? pin_in : pfs_pkg::LINE_IDLE;

  // registered pad drive, released at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_drv_q <= '0;
    end else if (ce) begin
      pad_drv_q <= sel ? alt_drv : gpio_drv;
    end
  end

  // gpio readback always shows the pin level
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_in_q <= 1'h0;
    end else if (ce) begin
      gpio_in_q <= pin_in;
    end
  end

endmodule

// ===== core/pfs_axil_slave.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// axi4-lite slave front end
// ----------------------------------------------------------------
module pfs_axil_slave #(
  parameter int ADDR_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic                   wr_fire,
  output logic [ADDR_W-1:0]      wr_addr,
  output pfs_pkg::pfs_wr_t       wr_req,
  input  wire logic              wr_hit,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit
);

  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  logic bvalid_d;
  logic rvalid_d;
  logic aw_take;
  logic w_take;
  logic ar_take;

  // handshake bookkeeping; address and data may come in either order
  always_comb begin
    aw_take   = s_awvalid & s_awready;
    w_take    = s_wvalid & s_wready;
    ar_take   = s_arvalid & s_arready;
    wr_fire   = aw_have_q & w_have_q & ~s_bvalid;
    aw_have_d = (aw_have_q | aw_take) & ~wr_fire;
    w_have_d  = (w_have_q | w_take) & ~wr_fire;
    bvalid_d  = wr_fire | (s_bvalid & ~s_bready);
    rvalid_d  = ar_take | (s_rvalid & ~s_rready);
  end

  // write channel state; one write under way at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q <= 1'h0;
      w_have_q  <= 1'h0;
      s_awready <= 1'h0;
      s_wready  <= 1'h0;
      s_bvalid  <= 1'h0;
      s_bresp   <= pfs_pkg::RESP_OKAY;
      wr_addr   <= '0;
      wr_req    <= '0;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      s_awready <= ~aw_have_d & ~bvalid_d;
      s_wready  <= ~w_have_d & ~bvalid_d;
      s_bvalid  <= bvalid_d;
      if (aw_take) begin
        wr_addr <= s_awaddr;
      end
      if (w_take) begin
        wr_req <= '{data: s_wdata, strb: s_wstrb};
      end
      if (wr_fire) begin
        s_bresp <= wr_hit ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
      end
    end
  end

  // read channel state; data is captured at the address edge
  always_ff @(posedge clk) begin
    if (rst) begin
      s_arready <= 1'h0;
      s_rvalid  <= 1'h0;
      s_rdata   <= '0;
      s_rresp   <= pfs_pkg::RESP_OKAY;
    end else if (ce) begin
      s_arready <= ~rvalid_d;
      s_rvalid  <= rvalid_d;
      if (ar_take) begin
        s_rdata <= rd_hit ? rd_data : 32'h00000000;
        s_rresp <= rd_hit ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_SLVERR;
      end
    end
  end

endmodule

// ===== core/pfs_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// How it works
// - port-1 bit 4 set drives the uart tx pin from uart transmit.
// - port-1 bit 0 set feeds the uart rx pin into uart receive.
// - port-2 bit 24 routes test-interface serial output to its pin.
// - port-2 bit 20 set with bit 0 clear drives lin data from uart transmit.
// - port-2 bits 20 and 0 clear take lin transmit data from internal pad.
// - port-2 bit 16 set feeds lin input to timing logic and uart.
// - port-2 bit 16 clear gives internal pad diagnostic readback.
// - port-2 bit 4 set outputs lin received data on its pin.
// - port-2 bit 0 set passes its pin through to lin transmit.
// - reset loads both function registers with their defaults.
// - both registers read back at their addresses as written.
// ----------------------------------------------------------------
module pfs_top #(
  parameter int ADDR_W = 32
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            ce,
  input  wire logic [ADDR_W-1:0]               s_awaddr,
  input  wire logic                            s_awvalid,
  output logic                                 s_awready,
  input  wire logic [31:0]                     s_wdata,
  input  wire logic [3:0]                      s_wstrb,
  input  wire logic                            s_wvalid,
  output logic                                 s_wready,
  output logic [1:0]                           s_bresp,
  output logic                                 s_bvalid,
  input  wire logic                            s_bready,
  input  wire logic [ADDR_W-1:0]               s_araddr,
  input  wire logic                            s_arvalid,
  output logic                                 s_arready,
  output logic [31:0]                          s_rdata,
  output logic [1:0]                           s_rresp,
  output logic                                 s_rvalid,
  input  wire logic                            s_rready,
  input  wire logic                            uart_txd,
  output logic                                 uart_rxd_q,
  input  wire logic                            test_if_data,
  input  wire logic                            test_if_gpio_out,
  output logic                                 test_if_pin_q,
  input  wire logic                            lin_rxd,
  input  wire logic                            diag_rxd,
  input  wire logic                            lin_tx_pad,
  output logic                                 lin_txd_q,
  output logic                                 bsd_link_rxd_q,
  output logic                                 lin_rx_pad_q,
  input  pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0] gpio_drv,
  input  wire logic [pfs_pkg::NPIN-1:0]        pin_in,
  output pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0] pin_drv_q,
  output logic [pfs_pkg::NPIN-1:0]             gpio_in_q
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------

  // decode needs the low twelve bits at least, and no more than 32
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
    $error("pfs_top: ADDR_W must lie in 12..32");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------

  logic [31:0]                          p1_q;
  logic [31:0]                          p2_q;
  logic                                 wr_fire;
  logic [ADDR_W-1:0]                    wr_addr;
  pfs_pkg::pfs_wr_t                     wr_req;
  logic                                 wr_p1;
  logic                                 wr_p2;
  logic                                 rd_p1;
  logic                                 rd_p2;
  logic [31:0]                          rd_data;
  logic [pfs_pkg::NPIN-1:0]             pin_sel;
  logic [pfs_pkg::NPIN-1:0]             alt_in;
  pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0] alt_drv;
  logic                                 lin_rx_path;
  logic                                 live_en;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------

  pfs_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_fire   (wr_fire),
    .wr_addr   (wr_addr),
    .wr_req    (wr_req),
    .wr_hit    (wr_p1 | wr_p2),
    .rd_data   (rd_data),
    .rd_hit    (rd_p1 | rd_p2)
  );

  // address decode on full width; anything else answers slverr
  always_comb begin
    wr_p1   = wr_addr == pfs_pkg::P1_ADDR[ADDR_W-1:0];
    wr_p2   = wr_addr == pfs_pkg::P2_ADDR[ADDR_W-1:0];
    rd_p1   = s_araddr == pfs_pkg::P1_ADDR[ADDR_W-1:0];
    rd_p2   = s_araddr == pfs_pkg::P2_ADDR[ADDR_W-1:0];
    rd_data = rd_p1 ? p1_q : (rd_p2 ? p2_q : 32'h00000000);
  end

  // ----------------------------------------------------------------
  // function registers
  // ----------------------------------------------------------------

  // byte lanes; reserved bits are stored too, so reads echo writes
  for (genvar b = 0; b < 4; b++) begin : g_byte
    always_ff @(posedge clk) begin
      if (rst) begin
        p1_q[8*b+:8] <= pfs_pkg::P1_RESET[8*b+:8];
        p2_q[8*b+:8] <= pfs_pkg::P2_RESET[8*b+:8];
      end else if (ce && wr_fire && wr_req.strb[b]) begin
        if (wr_p1) begin
          p1_q[8*b+:8] <= wr_req.data[8*b+:8];
        end
        if (wr_p2) begin
          p2_q[8*b+:8] <= wr_req.data[8*b+:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // two-way pins
  // ----------------------------------------------------------------

  // select and alternate drive per pin; input-only functions float the pad
  always_comb begin
    pin_sel[pfs_pkg::PIN_RX]    = p1_q[pfs_pkg::P1_RXD_BIT];
    pin_sel[pfs_pkg::PIN_TX]    = p1_q[pfs_pkg::P1_TXD_BIT];
    pin_sel[pfs_pkg::PIN_TXIN]  = p2_q[pfs_pkg::P2_TXIN_BIT];
    pin_sel[pfs_pkg::PIN_RXOUT] = p2_q[pfs_pkg::P2_RXOUT_BIT];
    alt_drv[pfs_pkg::PIN_RX]    = '{out: 1'h0, oe: 1'h0};
    alt_drv[pfs_pkg::PIN_TX]    = '{out: uart_txd, oe: 1'h1};
    alt_drv[pfs_pkg::PIN_TXIN]  = '{out: 1'h0, oe: 1'h0};
    alt_drv[pfs_pkg::PIN_RXOUT] = '{out: lin_rxd, oe: 1'h1};
  end

  for (genvar p = 0; p < pfs_pkg::NPIN; p++) begin : g_pin
    pfs_pad_mux u_pad (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .sel       (pin_sel[p]),
      .alt_drv   (alt_drv[p]),
      .gpio_drv  (gpio_drv[p]),
      .pin_in    (pin_in[p]),
      .pad_drv_q (pin_drv_q[p]),
      .gpio_in_q (gpio_in_q[p]),
      .alt_in    (alt_in[p])
    );
  end

  // ----------------------------------------------------------------
  // internal lin, uart and test-interface routing
  // ----------------------------------------------------------------

  // lin input path, idle high when disabled so the uart sees no break
  assign lin_rx_path = p2_q[pfs_pkg::P2_LINRX_BIT] ? lin_rxd : pfs_pkg::LINE_IDLE;

  // uart receive: both sources idle high, so an and merges them
  always_ff @(posedge clk) begin
    if (rst) begin
      uart_rxd_q <= pfs_pkg::LINE_IDLE;
    end else if (ce) begin
      uart_rxd_q <= alt_in[pfs_pkg::PIN_RX] & lin_rx_path;
    end
  end

  // lin timing logic input and the internal diagnostic pad
  always_ff @(posedge clk) begin
    if (rst) begin
      bsd_link_rxd_q <= pfs_pkg::LINE_IDLE;
      lin_rx_pad_q   <= 1'h0;
    end else if (ce) begin
      bsd_link_rxd_q <= lin_rx_path;
      lin_rx_pad_q <= p2_q[pfs_pkg::P2_LINRX_BIT] ? lin_rxd : diag_rxd;
    end
  end

  // lin transmit; the standalone pass-through wins over both sources
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_txd_q <= pfs_pkg::LINE_IDLE;
    end else if (ce) begin
      if (p2_q[pfs_pkg::P2_TXIN_BIT]) begin
        lin_txd_q <= alt_in[pfs_pkg::PIN_TXIN];
      end else if (p2_q[pfs_pkg::P2_LINTX_BIT]) begin
        lin_txd_q <= uart_txd;
      end else begin
        lin_txd_q <= lin_tx_pad;
      end
    end
  end

  // test-interface pin: test_if_data when that interface is enabled, else test_if_gpio_out
  always_ff @(posedge clk) begin
    if (rst) begin
      test_if_pin_q <= 1'h0;
    end else if (ce) begin
      test_if_pin_q <= p2_q[pfs_pkg::P2_TEST_IF_BIT] ? test_if_data : test_if_gpio_out;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // reset may drop on an edge; the sampled gate keeps that first edge quiet
  assign live_en = ce & ~rst;

  chk_tx_alt_drive: assert property (
    live_en && p1_q[pfs_pkg::P1_TXD_BIT] |=>
      pin_drv_q[pfs_pkg::PIN_TX].out == $past(uart_txd) && pin_drv_q[pfs_pkg::PIN_TX].oe)
    else $error("uart tx pin not driven by uart transmit");

  chk_tx_gpio_drive: assert property (
    live_en && !p1_q[pfs_pkg::P1_TXD_BIT] |=> pin_drv_q[pfs_pkg::PIN_TX] == $past(gpio_drv[pfs_pkg::PIN_TX]))
    else $error("uart tx pin not in gpio use");

  chk_rx_to_uart: assert property (
    live_en && p1_q[pfs_pkg::P1_RXD_BIT] && !p2_q[pfs_pkg::P2_LINRX_BIT] |=>
      uart_rxd_q == $past(pin_in[pfs_pkg::PIN_RX]) && !pin_drv_q[pfs_pkg::PIN_RX].oe)
    else $error("uart rx pin not fed to uart receive");

  chk_test_if_gate: assert property (
    live_en ##1 live_en |=>
      test_if_pin_q == ($past(p2_q[pfs_pkg::P2_TEST_IF_BIT]) ? $past(test_if_data) : $past(test_if_gpio_out)))
    else $error("test interface pin routing wrong");

  chk_lin_from_uart: assert property (
    live_en && p2_q[pfs_pkg::P2_LINTX_BIT] && !p2_q[pfs_pkg::P2_TXIN_BIT] |=> lin_txd_q == $past(uart_txd))
    else $error("lin data not from uart transmit");

  chk_lin_from_pad: assert property (
    live_en && !p2_q[pfs_pkg::P2_LINTX_BIT] && !p2_q[pfs_pkg::P2_TXIN_BIT] |=> lin_txd_q == $past(lin_tx_pad))
    else $error("lin data not from internal pad");

  chk_lin_rx_fanout: assert property (
    live_en && p2_q[pfs_pkg::P2_LINRX_BIT] && !p1_q[pfs_pkg::P1_RXD_BIT] |=>
      bsd_link_rxd_q == $past(lin_rxd) && uart_rxd_q == $past(lin_rxd))
    else $error("lin input not delivered to timing and uart");

  chk_diag_readback: assert property (
    live_en && !p2_q[pfs_pkg::P2_LINRX_BIT] |=> lin_rx_pad_q == $past(diag_rxd) && bsd_link_rxd_q)
    else $error("lin input path not disabled for readback");

  chk_rx_out_pin: assert property (
    live_en && p2_q[pfs_pkg::P2_RXOUT_BIT] |=>
      pin_drv_q[pfs_pkg::PIN_RXOUT].oe && pin_drv_q[pfs_pkg::PIN_RXOUT].out == $past(lin_rxd))
    else $error("lin received data not on its pin");

  chk_tx_in_pass: assert property (
    live_en && p2_q[pfs_pkg::P2_TXIN_BIT] |=>
      lin_txd_q == $past(pin_in[pfs_pkg::PIN_TXIN]) && !pin_drv_q[pfs_pkg::PIN_TXIN].oe)
    else $error("pass-through pin not reaching lin transmit");

  chk_reset_load: assert property (
    disable iff (1'b0)
    rst |=> p1_q == pfs_pkg::P1_RESET && p2_q == pfs_pkg::P2_RESET)
    else $error("function registers not at reset value");

  chk_read_back: assert property (
    live_en && s_arvalid && s_arready && rd_p2 |=>
      s_rvalid && s_rdata == $past(p2_q) && s_rresp == pfs_pkg::RESP_OKAY)
    else $error("port-2 read does not return register");

  chk_write_store: assert property (
    live_en && wr_fire && wr_p1 && wr_req.strb == 4'hF |=> p1_q == $past(wr_req.data) && s_bvalid)
    else $error("port-1 full write not stored");

endmodule

// ===== test/pfs_far_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: port pins and lin transceiver
// ----------------------------------------------------------------
module pfs_far_model (
  input  pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0] pin_drv,
  input  wire logic [pfs_pkg::NPIN-1:0]        ext_lvl,
  input  wire logic                            lin_txd,
  input  wire logic                            lin_bus,
  output logic [pfs_pkg::NPIN-1:0]             pin_in,
  output logic                                 lin_rxd
);
  // pad level: the chip wins while it drives, else the board drives it
  always_comb begin
    for (int i = 0; i < pfs_pkg::NPIN; i++) begin
      pin_in[i] = pin_drv[i].oe ? pin_drv[i].out : ext_lvl[i];
    end
  end

  // lin bus is wired-and, so the receiver echoes our own dominant bits
  assign lin_rxd = lin_bus & lin_txd;
endmodule

// ===== test/tb_port1_port2_function_select.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
// ----------------------------------------------------------------
// bench for the port function select block
// ----------------------------------------------------------------
module tb_port1_port2_function_select;
  typedef pfs_pkg::pfs_pad_t [pfs_pkg::NPIN-1:0] pfs_pads_t;

  logic        clk, rst, ce;
  logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
  logic [3:0]  s_wstrb;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0]  s_bresp, s_rresp;
  logic        uart_txd, uart_rxd_q, test_if_data, test_if_gpio_out, test_if_pin_q;
  logic        lin_rxd, diag_rxd, lin_tx_pad, lin_txd_q, bsd_link_rxd_q, lin_rx_pad_q, lin_bus;
  pfs_pads_t   gpio_drv, pin_drv_q;
  logic [3:0]  pin_in, gpio_in_q, ext_lvl;
  int          num_errors = 0;
  int          num_checks = 0;

  // configurations cover every select bit, incl. both lin transmit sources
  logic [31:0] cfg1 [5] = '{32'h00000001, 32'h00000011, 32'h00000010, 32'h00000001, 32'h00000011};
  logic [31:0] cfg2 [5] = '{32'h00000000, 32'h01110011, 32'h00110000, 32'h00010010, 32'h01110001};
  logic [17:0] vec [4]  = '{18'h155A5, 18'h0F0F3, 18'h30F0C, 18'h2AA5A};

  pfs_top DUT (
    .clk(clk), .rst(rst), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .uart_txd(uart_txd), .uart_rxd_q(uart_rxd_q), .test_if_data(test_if_data),
    .test_if_gpio_out(test_if_gpio_out), .test_if_pin_q(test_if_pin_q), .lin_rxd(lin_rxd),
    .diag_rxd(diag_rxd), .lin_tx_pad(lin_tx_pad), .lin_txd_q(lin_txd_q),
    .bsd_link_rxd_q(bsd_link_rxd_q), .lin_rx_pad_q(lin_rx_pad_q), .gpio_drv(gpio_drv),
    .pin_in(pin_in), .pin_drv_q(pin_drv_q), .gpio_in_q(gpio_in_q)
  );

  pfs_far_model far (
    .pin_drv(pin_drv_q), .ext_lvl(ext_lvl), .lin_txd(lin_txd_q),
    .lin_bus(lin_bus), .pin_in(pin_in), .lin_rxd(lin_rxd)
  );

  // 20 mhz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // bus tasks, entered and left just after a rising edge
  // ----------------------------------------------------------------
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) begin
        `CHK(s_bresp, er)
        s_bready <= 1'b0;
        done = 1'b1;
      end
    end
    // let one edge pass so the next request never lands in this step
    @(posedge clk);
  endtask

  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) begin
        `CHK(s_rdata, ed)
        `CHK(s_rresp, er)
        s_rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // stimulus and routing expectations
  // ----------------------------------------------------------------
  task automatic apply(input logic [17:0] v);
    uart_txd     <= v[0];
    test_if_data     <= v[1];
    test_if_gpio_out <= v[2];
    diag_rxd     <= v[3];
    lin_tx_pad   <= v[4];
    lin_bus      <= v[5];
    ext_lvl      <= v[9:6];
    gpio_drv     <= pfs_pads_t'(v[17:10]);
  endtask

  // expected levels rebuilt from the select bits and the stable inputs
  task automatic check_route(input logic [31:0] p1, input logic [31:0] p2);
    logic              ltx, lrx;
    pfs_pkg::pfs_pad_t alt1, alt3;
    ltx  = p2[0] ? ext_lvl[2] : (p2[20] ? uart_txd : lin_tx_pad);
    lrx  = lin_bus & ltx;
    alt1 = '{out: uart_txd, oe: 1'b1};
    alt3 = '{out: lrx, oe: 1'b1};
    `CHK(lin_txd_q, ltx)
    `CHK(bsd_link_rxd_q, p2[16] ? lrx : 1'b1)
    `CHK(lin_rx_pad_q, p2[16] ? lrx : diag_rxd)
    `CHK(test_if_pin_q, p2[24] ? test_if_data : test_if_gpio_out)
    `CHK(uart_rxd_q, (p1[0] ? ext_lvl[0] : 1'b1) & (p2[16] ? lrx : 1'b1))
    `CHK(pin_drv_q[1], p1[4] ? alt1 : gpio_drv[1])
    `CHK(pin_drv_q[3], p2[4] ? alt3 : gpio_drv[3])
    if (p1[0]) `CHK(pin_drv_q[0].oe, 1'b0) else `CHK(pin_drv_q[0], gpio_drv[0])
    if (p2[0]) `CHK(pin_drv_q[2].oe, 1'b0) else `CHK(pin_drv_q[2], gpio_drv[2])
    `CHK(gpio_in_q, pin_in)
  endtask

  task automatic settle_and_check(input logic [31:0] p1, input logic [31:0] p2);
    // pin loop goes through up to three flop stages (pass-through pin to rx-out pin to readback), four edges cover it
    repeat (4) @(posedge clk);
    @(negedge clk);
    check_route(p1, p2);
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    s_awaddr = 32'h0;
    s_araddr = 32'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'h0;
    apply(vec[0]);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(pfs_pkg::P1_ADDR, pfs_pkg::P1_RESET, pfs_pkg::RESP_OKAY);
    axr(pfs_pkg::P2_ADDR, pfs_pkg::P2_RESET, pfs_pkg::RESP_OKAY);
    axw(pfs_pkg::P2_ADDR, 32'hA5C33C5A, pfs_pkg::RESP_OKAY);
    axr(pfs_pkg::P2_ADDR, 32'hA5C33C5A, pfs_pkg::RESP_OKAY);
    // unmapped neighbour: refused and leaves the registers alone
    axw(32'hFFFF0D0C, 32'h00001234, pfs_pkg::RESP_SLVERR);
    axr(32'hFFFF0D0C, 32'h00000000, pfs_pkg::RESP_SLVERR);
    axr(pfs_pkg::P2_ADDR, 32'hA5C33C5A, pfs_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      axw(pfs_pkg::P1_ADDR, cfg1[i], pfs_pkg::RESP_OKAY);
      axw(pfs_pkg::P2_ADDR, cfg2[i], pfs_pkg::RESP_OKAY);
      axr(pfs_pkg::P1_ADDR, cfg1[i], pfs_pkg::RESP_OKAY);
      for (int j = 0; j < 4; j++) begin
        apply(vec[j]);
        settle_and_check(cfg1[i], cfg2[i]);
      end
    end
    // clock enable low freezes the routed outputs
    ce <= 1'b0;
    apply(vec[0]);
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(test_if_pin_q, vec[3][1])
    @(posedge clk);
    ce <= 1'b1;
    settle_and_check(cfg1[4], cfg2[4]);
    // second reset in mid-run restores both defaults
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(pfs_pkg::P1_ADDR, pfs_pkg::P1_RESET, pfs_pkg::RESP_OKAY);
    axr(pfs_pkg::P2_ADDR, pfs_pkg::P2_RESET, pfs_pkg::RESP_OKAY);
    settle_and_check(pfs_pkg::P1_RESET, pfs_pkg::P2_RESET);
    stop_test();
  end

  // watchdog: the run needs about two hundred cycles
  initial begin
    #(20000 * 50);
    num_errors++;
    stop_test();
  end
endmodule
